// ==== rtl/vte_pkg.sv ====
// Summary of operation
// - Host holds reset low two cycles first
// - Engine runs independently of other blocks
// - Only one transform direction at a time
// - Data two's complement; angles unsigned turn fractions
// - Reverse angle write starts reverse transform
// - Two-of-three mode derives u as negated sum
// - Control bit 10 selects mode, clear at reset
// - Host writes phase inputs before reverse angle
// - Reverse transform completes within 37 cycles
// - Beta is (w minus v) over root three
// - Flux and torque from reverse rotation
// - Sine and cosine generated internally
// - Voltages written first, forward angle starts
// - Host sets three-of-three mode before forward
// - Forward transform completes within 40 cycles
// - Alpha and beta voltage from forward rotation
// - Forward Clarke gives three phase voltages
// - Control bit 6 enables completion interrupt
// - Completion sets status bit 1 when control bit 6 is set
// - Host must not write during a transform
// - Status bit 11; status read clears flags
// - Reset clears completion interrupt enable
package vte_pkg;
  localparam int DW = 12;
  localparam int AW = 4;
  localparam logic [3:0] ADDR_CURRENT_IN_U = 4'h0;
  localparam logic [3:0] ADDR_CURRENT_IN_V = 4'h1;
  localparam logic [3:0] ADDR_CURRENT_IN_W = 4'h2;
  localparam logic [3:0] ADDR_REVERSE_ANGLE = 4'h3;
  localparam logic [3:0] ADDR_ALPHA_CURRENT = 4'h4;
  localparam logic [3:0] ADDR_BETA_CURRENT = 4'h5;
  localparam logic [3:0] ADDR_FLUX_CURRENT = 4'h6;
  localparam logic [3:0] ADDR_TORQUE_CURRENT = 4'h7;
  localparam logic [3:0] ADDR_DIRECT_VOLTAGE = 4'h8;
  localparam logic [3:0] ADDR_QUADRATURE_VOLTAGE = 4'h9;
  localparam logic [3:0] ADDR_FORWARD_ANGLE = 4'hA;
  localparam logic [3:0] ADDR_PHASE_OUT_U = 4'hB;
  localparam logic [3:0] ADDR_PHASE_OUT_V = 4'hC;
  localparam logic [3:0] ADDR_PHASE_OUT_W = 4'hD;
  localparam logic [3:0] ADDR_SYSTEM_CONTROL_WORD = 4'hE;
  localparam logic [3:0] ADDR_SYSTEM_STATUS_WORD = 4'hF;
  localparam int CTRL_IRQ_EN_BIT = 6;
  localparam int CTRL_LEVEL_BIT = 8;
  localparam int CTRL_MODE3_BIT = 10;
  localparam int STAT_VT_BIT = 1;
  localparam int STAT_ANY_BIT = 11;
  localparam logic [11:0] WREG_RESET = 12'h000;
  localparam int REV_CYCLES = 37;
  localparam int FWD_CYCLES = 40;
  localparam int RESET_HOLD_CYCLES = 2;
  localparam int CORDIC_STEPS = 14;
  localparam int FRAC_BITS = 14;
  localparam logic signed [17:0] CORDIC_GAIN = 18'sh026DD;
  localparam logic signed [17:0] INV_SQRT3 = 18'sh024F3;
  localparam logic signed [17:0] HALF_SQRT3 = 18'sh0376D;
  localparam logic [31:0] APB_CMD_OFS = 32'h00000000;
  localparam logic [31:0] APB_STAT_OFS = 32'h00000004;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_READ_BIT = 4;
  localparam int CMD_DATA_LSB = 16;
  localparam int HSTAT_BUSY_BIT = 0;
  localparam int HSTAT_IRQ_BIT = 1;
  localparam int HSTAT_DATA_LSB = 16;

  // Arctangent of 2^-i, turn scaled to 65536
  function automatic logic [16:0] vte_atan(input logic [3:0] i);
    case (i)
      4'h0: vte_atan = 17'h02000;
      4'h1: vte_atan = 17'h012E4;
      4'h2: vte_atan = 17'h009FB;
      4'h3: vte_atan = 17'h00511;
      4'h4: vte_atan = 17'h0028B;
      4'h5: vte_atan = 17'h00146;
      4'h6: vte_atan = 17'h000A3;
      4'h7: vte_atan = 17'h00051;
      4'h8: vte_atan = 17'h00029;
      4'h9: vte_atan = 17'h00014;
      4'hA: vte_atan = 17'h0000A;
      4'hB: vte_atan = 17'h00005;
      4'hC: vte_atan = 17'h00003;
      default: vte_atan = 17'h00001;
    endcase
  endfunction : vte_atan
endpackage : vte_pkg

// ==== rtl/vte_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface vte_if;
  logic reset_n;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic [3:0] addr;
  logic [11:0] host_dq_o;
  logic host_dq_oe_n;
  logic [11:0] dev_dq_o;
  logic dev_dq_oe_n;
  logic irq_o;
  logic irq_oe_n;
  wire [11:0] dq;
  wire irq_n;
  // Undriven data bus floats high; open-drain irq pulled up
  assign dq = !dev_dq_oe_n ? dev_dq_o : (!host_dq_oe_n ? host_dq_o : 12'hFFF);
  assign irq_n = irq_oe_n ? 1'b1 : irq_o;
  modport device (input reset_n, cs_n, wr_n, rd_n, addr, dq,
                  output dev_dq_o, dev_dq_oe_n, irq_o, irq_oe_n);
  modport host (output reset_n, cs_n, wr_n, rd_n, addr, host_dq_o, host_dq_oe_n,
                input dq, irq_n);
endinterface : vte_if
`default_nettype wire

// ==== rtl/vte_device.sv ====
`timescale 1ns/1ns
`default_nettype none
module vte_device (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  vte_if.device bus,
  output logic xform_busy,
  output logic xform_done
);
  typedef enum logic [1:0] {VTE_IDLE, VTE_REV, VTE_FWD} vte_state_type;

  vte_state_type state_r;
  logic [5:0] cnt_r;
  logic signed [17:0] cx_r;
  logic signed [17:0] cy_r;
  logic signed [16:0] cz_r;
  logic [1:0] quad_r;
  logic [11:0] wreg_r [0:15];
  logic [11:0] alpha_current_r;
  logic [11:0] beta_current_r;
  logic [11:0] flux_current_r;
  logic [11:0] torque_current_r;
  logic [11:0] phase_out_u_r;
  logic [11:0] phase_out_v_r;
  logic [11:0] phase_out_w_r;
  logic stat_vt_r;
  logic stat_any_r;
  logic irq_drive_r;
  logic [11:0] rdata_r;
  logic rd_drive_r;
  logic [11:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Saturate to the register width instead of wrapping
  function automatic logic signed [11:0] vte_sat(input logic signed [23:0] v);
    if (v > 24'sh0007FF)
      vte_sat = 12'sh7FF;
    else if (v < -24'sh000800)
      vte_sat = 12'sh800;
    else
      vte_sat = v[11:0];
  endfunction : vte_sat

  function automatic logic signed [21:0] vte_mul(input logic signed [17:0] a,
                                                 input logic signed [17:0] b);
    logic signed [35:0] p;
    p = a * b;
    vte_mul = p[35:vte_pkg::FRAC_BITS];
  endfunction : vte_mul

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; the link shares clk_sys so no synchronisers are needed
  wire logic soft_rst = !bus.reset_n;
  wire logic wr_hit = !bus.cs_n && !bus.wr_n;
  wire logic rd_hit = !bus.cs_n && !bus.rd_n;
  wire logic idle = state_r == VTE_IDLE;
  wire logic start_rev = wr_hit && idle && bus.addr == vte_pkg::ADDR_REVERSE_ANGLE;
  wire logic start_fwd = wr_hit && idle && bus.addr == vte_pkg::ADDR_FORWARD_ANGLE;
  wire logic rd_stat = rd_hit && bus.addr == vte_pkg::ADDR_SYSTEM_STATUS_WORD;
  wire logic writable = !(bus.addr inside {vte_pkg::ADDR_ALPHA_CURRENT,
    vte_pkg::ADDR_BETA_CURRENT, vte_pkg::ADDR_FLUX_CURRENT, vte_pkg::ADDR_TORQUE_CURRENT,
    vte_pkg::ADDR_PHASE_OUT_U, vte_pkg::ADDR_PHASE_OUT_V, vte_pkg::ADDR_PHASE_OUT_W,
    vte_pkg::ADDR_SYSTEM_STATUS_WORD});
  wire logic [11:0] ctrl = wreg_r[vte_pkg::ADDR_SYSTEM_CONTROL_WORD];
  wire logic mode3 = ctrl[vte_pkg::CTRL_MODE3_BIT];
  wire logic [5:0] last_cnt = (state_r == VTE_REV) ? 6'(vte_pkg::REV_CYCLES - 1)
                                                   : 6'(vte_pkg::FWD_CYCLES - 1);
  wire logic fin = !idle && cnt_r == last_cnt;
  wire logic set_vt = fin && ctrl[vte_pkg::CTRL_IRQ_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Iterative sine/cosine generator, one step per cycle
  wire logic [3:0] step = cnt_r[3:0];
  wire logic rot_pos = !cz_r[16];
  wire logic signed [17:0] cx_sh = cx_r >>> step;
  wire logic signed [17:0] cy_sh = cy_r >>> step;
  wire logic signed [16:0] atan_v = signed'(vte_pkg::vte_atan(step));
  wire logic signed [17:0] cx_nxt = rot_pos ? cx_r - cy_sh : cx_r + cy_sh;
  wire logic signed [17:0] cy_nxt = rot_pos ? cy_r + cx_sh : cy_r - cx_sh;
  wire logic signed [16:0] cz_nxt = rot_pos ? cz_r - atan_v : cz_r + atan_v;
  wire logic cordic_run = !idle && cnt_r < 6'(vte_pkg::CORDIC_STEPS);
  // Quadrant from the two angle MSBs; the generator only covers 0 to 90 degrees
  wire logic signed [17:0] cos_v = (quad_r == 2'h0) ? cx_r : (quad_r == 2'h1) ? -cy_r :
                                   (quad_r == 2'h2) ? -cx_r : cy_r;
  wire logic signed [17:0] sin_v = (quad_r == 2'h0) ? cy_r : (quad_r == 2'h1) ? cx_r :
                                   (quad_r == 2'h2) ? -cy_r : -cx_r;
  // Ten fraction bits span one quarter turn, 16384 on the generator's scale
  wire logic [16:0] angle_z = {3'b000, bus.dq[9:0], 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Reverse Clarke and Park
  wire logic signed [17:0] in_u = 18'(signed'(wreg_r[vte_pkg::ADDR_CURRENT_IN_U]));
  wire logic signed [17:0] in_v = 18'(signed'(wreg_r[vte_pkg::ADDR_CURRENT_IN_V]));
  wire logic signed [17:0] in_w = 18'(signed'(wreg_r[vte_pkg::ADDR_CURRENT_IN_W]));
  wire logic signed [11:0] derived_u = vte_sat(24'(-(in_v + in_w)));
  wire logic signed [11:0] alpha_c = mode3 ? in_u[11:0] : derived_u;
  wire logic signed [11:0] beta_c = vte_sat(24'(vte_mul(in_w - in_v, vte_pkg::INV_SQRT3)));
  wire logic signed [17:0] alpha_x = 18'(alpha_c);
  wire logic signed [17:0] beta_x = 18'(beta_c);
  wire logic signed [11:0] flux_c =
    vte_sat(24'(vte_mul(alpha_x, cos_v)) + 24'(vte_mul(beta_x, sin_v)));
  wire logic signed [11:0] torque_c =
    vte_sat(24'(vte_mul(beta_x, cos_v)) - 24'(vte_mul(alpha_x, sin_v)));

  ////////////////////////////////////////////////////////////////////////////
  // Forward Park and Clarke
  wire logic signed [17:0] dv = 18'(signed'(wreg_r[vte_pkg::ADDR_DIRECT_VOLTAGE]));
  wire logic signed [17:0] qv = 18'(signed'(wreg_r[vte_pkg::ADDR_QUADRATURE_VOLTAGE]));
  wire logic signed [11:0] alpha_voltage =
    vte_sat(24'(vte_mul(dv, cos_v)) - 24'(vte_mul(qv, sin_v)));
  wire logic signed [11:0] beta_voltage =
    vte_sat(24'(vte_mul(dv, sin_v)) + 24'(vte_mul(qv, cos_v)));
  wire logic signed [23:0] neg_half = -(24'(alpha_voltage) >>> 1);
  wire logic signed [23:0] beta_part = 24'(vte_mul(18'(beta_voltage), vte_pkg::HALF_SQRT3));
  wire logic signed [11:0] phase_v_c = vte_sat(neg_half - beta_part);
  wire logic signed [11:0] phase_w_c = vte_sat(neg_half + beta_part);

  ////////////////////////////////////////////////////////////////////////////
  // Read selection
  wire logic [11:0] stat_word = (12'(stat_any_r) << vte_pkg::STAT_ANY_BIT) |
                                (12'(stat_vt_r) << vte_pkg::STAT_VT_BIT);
  always_comb
  begin
    case (bus.addr)
      vte_pkg::ADDR_ALPHA_CURRENT: rd_mux = alpha_current_r;
      vte_pkg::ADDR_BETA_CURRENT: rd_mux = beta_current_r;
      vte_pkg::ADDR_FLUX_CURRENT: rd_mux = flux_current_r;
      vte_pkg::ADDR_TORQUE_CURRENT: rd_mux = torque_current_r;
      vte_pkg::ADDR_PHASE_OUT_U: rd_mux = phase_out_u_r;
      vte_pkg::ADDR_PHASE_OUT_V: rd_mux = phase_out_v_r;
      vte_pkg::ADDR_PHASE_OUT_W: rd_mux = phase_out_w_r;
      vte_pkg::ADDR_SYSTEM_STATUS_WORD: rd_mux = stat_word;
      default: rd_mux = wreg_r[bus.addr];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host-writable registers; control word clears at reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 16; i++)
        wreg_r[i] <= vte_pkg::WREG_RESET;
    end
    else if (ce)
    begin
      if (soft_rst)
      begin
        for (int i = 0; i < 16; i++)
          wreg_r[i] <= vte_pkg::WREG_RESET;
      end
      else if (wr_hit && writable)
        wreg_r[bus.addr] <= bus.dq;
    end
  end

  // Sequencer; a start while busy is ignored so directions never overlap
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= VTE_IDLE;
      cnt_r <= 6'h00;
      cx_r <= 18'sh00000;
      cy_r <= 18'sh00000;
      cz_r <= 17'sh00000;
      quad_r <= 2'h0;
    end
    else if (ce)
    begin
      if (soft_rst)
        state_r <= VTE_IDLE;
      else if (idle && (start_rev || start_fwd))
      begin
        state_r <= start_rev ? VTE_REV : VTE_FWD;
        cnt_r <= 6'h00;
        cx_r <= vte_pkg::CORDIC_GAIN;
        cy_r <= 18'sh00000;
        cz_r <= signed'(angle_z);
        quad_r <= bus.dq[11:10];
      end
      else if (!idle)
      begin
        cnt_r <= cnt_r + 6'h01;
        if (cordic_run)
        begin
          cx_r <= cx_nxt;
          cy_r <= cy_nxt;
          cz_r <= cz_nxt;
        end
        if (fin)
          state_r <= VTE_IDLE;
      end
    end
  end

  // Result registers change only at completion of their own direction
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      alpha_current_r <= 12'h000;
      beta_current_r <= 12'h000;
      flux_current_r <= 12'h000;
      torque_current_r <= 12'h000;
    end
    else if (ce && fin && state_r == VTE_REV)
    begin
      alpha_current_r <= alpha_c;
      beta_current_r <= beta_c;
      flux_current_r <= flux_c;
      torque_current_r <= torque_c;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      phase_out_u_r <= 12'h000;
      phase_out_v_r <= 12'h000;
      phase_out_w_r <= 12'h000;
    end
    else if (ce && fin && state_r == VTE_FWD)
    begin
      phase_out_u_r <= alpha_voltage;
      phase_out_v_r <= phase_v_c;
      phase_out_w_r <= phase_w_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: a completion in the read cycle survives the clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stat_vt_r <= 1'b0;
      stat_any_r <= 1'b0;
      irq_drive_r <= 1'b0;
    end
    else if (ce)
    begin
      stat_vt_r <= !soft_rst && (set_vt || (stat_vt_r && !rd_stat));
      stat_any_r <= !soft_rst && (set_vt || (stat_any_r && !rd_stat));
      // Edge mode pulls the line one cycle; level mode until status read
      irq_drive_r <= !soft_rst && (set_vt || (irq_drive_r && !rd_stat &&
                     ctrl[vte_pkg::CTRL_LEVEL_BIT]));
    end
  end

  // Read data is driven for the one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= 12'h000;
      rd_drive_r <= 1'b0;
    end
    else if (ce)
    begin
      rd_drive_r <= rd_hit;
      if (rd_hit)
        rdata_r <= rd_mux;
    end
  end

  assign bus.dev_dq_o = rdata_r;
  assign bus.dev_dq_oe_n = !rd_drive_r;
  assign bus.irq_o = 1'b0;
  assign bus.irq_oe_n = !irq_drive_r;
  // No handshake with any other block is needed to start or finish
  assign xform_busy = !idle;
  assign xform_done = fin;
endmodule : vte_device
`default_nettype wire

// ==== rtl/vte_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module vte_host (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  vte_if.host bus
);
  typedef enum logic [2:0] {VTH_RESET, VTH_IDLE, VTH_STROBE, VTH_READ, VTH_GUARD}
    vth_state_type;

  vth_state_type state_r;
  logic [5:0] cnt_r;
  logic reset_n_r;
  logic cs_n_r;
  logic wr_n_r;
  logic rd_n_r;
  logic oe_n_r;
  logic is_read_r;
  logic [3:0] addr_r;
  logic [11:0] wdata_r;
  logic [11:0] rd_data_r;
  logic [31:0] prdata_r;

  ////////////////////////////////////////////////////////////////////////////
  wire logic hit_cmd = paddr == vte_pkg::APB_CMD_OFS;
  wire logic hit_stat = paddr == vte_pkg::APB_STAT_OFS;
  wire logic apb_done = psel && penable;
  wire logic busy = state_r != VTH_IDLE;
  // A command written while busy is dropped; software polls the busy bit
  wire logic take = apb_done && pwrite && hit_cmd && !busy;
  wire logic angle_wr = !is_read_r && (addr_r == vte_pkg::ADDR_REVERSE_ANGLE ||
                                       addr_r == vte_pkg::ADDR_FORWARD_ANGLE);
  wire logic [31:0] stat_word = (32'(rd_data_r) << vte_pkg::HSTAT_DATA_LSB) |
                                (32'(!bus.irq_n) << vte_pkg::HSTAT_IRQ_BIT) |
                                (32'(busy) << vte_pkg::HSTAT_BUSY_BIT);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      prdata_r <= 32'h00000000;
    else if (ce && psel && !penable)
      prdata_r <= hit_stat ? stat_word : 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= VTH_RESET;
      cnt_r <= 6'h00;
      reset_n_r <= 1'b0;
      cs_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      is_read_r <= 1'b0;
      addr_r <= 4'h0;
      wdata_r <= 12'h000;
      rd_data_r <= 12'h000;
    end
    else if (ce)
    begin
      case (state_r)
        VTH_RESET:
        begin
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'(vte_pkg::RESET_HOLD_CYCLES - 1))
          begin
            reset_n_r <= 1'b1;
            state_r <= VTH_IDLE;
          end
        end
        VTH_IDLE:
          if (take)
          begin
            addr_r <= pwdata[vte_pkg::CMD_ADDR_LSB +: 4];
            is_read_r <= pwdata[vte_pkg::CMD_READ_BIT];
            wdata_r <= pwdata[vte_pkg::CMD_DATA_LSB +: 12];
            cs_n_r <= 1'b0;
            rd_n_r <= !pwdata[vte_pkg::CMD_READ_BIT];
            wr_n_r <= pwdata[vte_pkg::CMD_READ_BIT];
            oe_n_r <= pwdata[vte_pkg::CMD_READ_BIT];
            state_r <= VTH_STROBE;
          end
        VTH_STROBE:
        begin
          cs_n_r <= 1'b1;
          wr_n_r <= 1'b1;
          rd_n_r <= 1'b1;
          oe_n_r <= 1'b1;
          cnt_r <= 6'h00;
          // Keep the bus quiet while a transform runs
          state_r <= is_read_r ? VTH_READ : (angle_wr ? VTH_GUARD : VTH_IDLE);
        end
        VTH_READ:
        begin
          rd_data_r <= bus.dq;
          state_r <= VTH_IDLE;
        end
        VTH_GUARD:
        begin
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'(vte_pkg::FWD_CYCLES - 1))
            state_r <= VTH_IDLE;
        end
        default:
          state_r <= VTH_IDLE;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = apb_done && !hit_cmd && !hit_stat;
  assign bus.reset_n = reset_n_r;
  assign bus.cs_n = cs_n_r;
  assign bus.wr_n = wr_n_r;
  assign bus.rd_n = rd_n_r;
  assign bus.addr = addr_r;
  assign bus.host_dq_o = wdata_r;
  assign bus.host_dq_oe_n = oe_n_r;
endmodule : vte_host
`default_nettype wire

// ==== tb/vte_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module vte_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [3:0] addr,
  input wire logic dev_dq_oe_n,
  input wire logic irq_oe_n,
  input wire logic xform_busy,
  input wire logic xform_done
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Angle writes while busy must start nothing, so idle is part of a start
  wire wr_s = !cs_n && !wr_n && reset_n;
  wire go_rev = wr_s && !xform_busy && addr == vte_pkg::ADDR_REVERSE_ANGLE;
  wire go_fwd = wr_s && !xform_busy && addr == vte_pkg::ADDR_FORWARD_ANGLE;
  //////////////////////////////
  rev_start_a: assert property (go_rev |=> xform_busy && !xform_done)
    else $error("reverse start not taken");
  rev_len_a: assert property (go_rev |-> ##37 xform_done ##1 !xform_busy)
    else $error("reverse length wrong");
  fwd_len_a: assert property (go_fwd |-> ##40 xform_done ##1 !xform_busy)
    else $error("forward length wrong");
  busy_cause_a: assert property ($rose(xform_busy) |-> $past(go_rev || go_fwd))
    else $error("busy without angle write");
  done_end_a: assert property (xform_done |-> xform_busy ##1 !xform_busy)
    else $error("done outside one transform");
  irq_cause_a: assert property ($fell(irq_oe_n) |-> $past(xform_done))
    else $error("irq without completion");
  rd_answer_a: assert property (!cs_n && !rd_n && reset_n |=> !dev_dq_oe_n ##1 dev_dq_oe_n)
    else $error("read answer wrong");
  reset_abort_a: assert property (!reset_n |=> !xform_busy)
    else $error("busy under engine reset");
  //////////////////////////////
  cover property (go_rev);
  cover property (go_fwd);
  cover property ($fell(irq_oe_n));
endmodule : vte_assertions
`default_nettype wire

// ==== tb/test_vector_transform_engine.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_vector_transform_engine;
  typedef struct {
    int fwd, m3, a, b, c, ang, e0, e1, e2, e3;
  } vte_row_type;
  logic clk_sys;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic xform_busy;
  logic xform_done;
  logic [31:0] rdat;
  logic serr;
  logic [31:0] st;
  int err_count;
  int checked;
  int ins [3];
  int exp [4];
  int ib, ni, ob;
  vte_row_type rows [10];
  vte_row_type r;
  //////////////////////////////
  vte_if i_vte_if ();
  vte_device i_vte_device (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .bus(i_vte_if),
    .xform_busy(xform_busy), .xform_done(xform_done));
  vte_host i_vte_host (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(i_vte_if));
  vte_assertions i_vte_assertions (.clk_sys(clk_sys), .rst(rst),
    .reset_n(i_vte_if.reset_n), .cs_n(i_vte_if.cs_n), .wr_n(i_vte_if.wr_n),
    .rd_n(i_vte_if.rd_n), .addr(i_vte_if.addr), .dev_dq_oe_n(i_vte_if.dev_dq_oe_n),
    .irq_oe_n(i_vte_if.irq_oe_n), .xform_busy(xform_busy), .xform_done(xform_done));
  //////////////////////////////
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic hang;
    err_count++;
    finish_test();
  endtask : hang

  // Exact compare when tol is zero, else signed window for rounding
  task automatic check(input string nm, input logic [11:0] seen, input int ex, input int tol);
    int s;
    s = $signed(seen);
    checked++;
    if ($isunknown(seen) || (tol == 0 ? seen !== ex[11:0] : (s - ex > tol || ex - s > tol)))
    begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, ex, s);
    end
  endtask : check

  task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      if (++n > 20)
        hang();
      @(posedge clk_sys);
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polling keeps the host from writing while a transform runs
  task automatic wait_idle;
    int n;
    n = 0;
    st = 32'hFFFFFFFF;
    while (st[vte_pkg::HSTAT_BUSY_BIT] !== 1'b0)
    begin
      if (++n > 100)
        hang();
      apb(1'b0, vte_pkg::APB_STAT_OFS, 32'h00000000);
      st = rdat;
    end
  endtask : wait_idle

  task automatic dev(input logic rd, input logic [3:0] ad, input logic [11:0] d);
    wait_idle();
    apb(1'b1, vte_pkg::APB_CMD_OFS, {4'h0, d, 11'h000, rd, ad});
    wait_idle();
  endtask : dev
  //////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    err_count = 0;
    checked = 0;
    rows = '{'{0, 0, 777, -300, 300, 0, 0, 346, 0, 346},
      '{0, 1, 500, -250, -250, 1024, 500, 0, 0, -500},
      '{0, 0, 0, 100, 200, 2048, -300, 58, 300, -58},
      '{0, 1, 2000, 0, 0, 3072, 2000, 0, 0, 2000},
      '{0, 1, 1000, -500, -500, 512, 1000, 0, 707, -707},
      '{0, 0, 0, -2048, -2048, 0, 2047, 0, 2047, 0},
      '{1, 1, 1000, 0, 0, 0, 1000, -500, -500, 0},
      '{1, 1, 0, 800, 0, 1024, -800, 400, 400, 0},
      '{1, 1, 600, 0, 0, 1024, 0, -520, 520, 0},
      '{1, 1, 1000, 0, 0, 512, 707, -966, 259, 0}};
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    dev(1'b1, vte_pkg::ADDR_SYSTEM_CONTROL_WORD, 12'h000);
    check("control", st[27:16], 0, 0);
    foreach (rows[i])
    begin
      r = rows[i];
      ins = '{r.a, r.b, r.c};
      exp = '{r.e0, r.e1, r.e2, r.e3};
      ib = r.fwd ? 8 : 0;
      ni = r.fwd ? 2 : 3;
      ob = r.fwd ? 11 : 4;
      dev(1'b0, vte_pkg::ADDR_SYSTEM_CONTROL_WORD, {1'b0, r.m3[0], 3'h0, 1'b1, 6'h00});
      for (int k = 0; k < ni; k++)
        dev(1'b0, 4'(ib + k), 12'(ins[k]));
      dev(1'b0, 4'(ib + ni), 12'(r.ang));
      for (int k = 0; k < 4 - r.fwd; k++)
      begin
        dev(1'b1, 4'(ob + k), 12'h000);
        check("result", st[27:16], exp[k], 3);
      end
      dev(1'b1, vte_pkg::ADDR_SYSTEM_STATUS_WORD, 12'h000);
      check("status", st[27:16], 32'h802, 0);
    end
    // Forward runs must leave the last reverse results alone
    dev(1'b0, vte_pkg::ADDR_ALPHA_CURRENT, 12'h123);
    dev(1'b1, vte_pkg::ADDR_FLUX_CURRENT, 12'h000);
    check("flux kept", st[27:16], 2047, 3);
    dev(1'b1, vte_pkg::ADDR_ALPHA_CURRENT, 12'h000);
    check("alpha kept", st[27:16], 2047, 3);
    dev(1'b1, vte_pkg::ADDR_SYSTEM_STATUS_WORD, 12'h000);
    check("status clear", st[27:16], 0, 0);
    dev(1'b0, vte_pkg::ADDR_SYSTEM_CONTROL_WORD, 12'h540);
    dev(1'b0, vte_pkg::ADDR_REVERSE_ANGLE, 12'h000);
    check("irq held", {11'h000, st[vte_pkg::HSTAT_IRQ_BIT]}, 1, 0);
    dev(1'b1, vte_pkg::ADDR_SYSTEM_STATUS_WORD, 12'h000);
    check("status level", st[27:16], 32'h802, 0);
    check("irq freed", {11'h000, st[vte_pkg::HSTAT_IRQ_BIT]}, 0, 0);
    dev(1'b0, vte_pkg::ADDR_SYSTEM_CONTROL_WORD, 12'h400);
    dev(1'b0, vte_pkg::ADDR_REVERSE_ANGLE, 12'h000);
    dev(1'b1, vte_pkg::ADDR_SYSTEM_STATUS_WORD, 12'h000);
    check("status masked", st[27:16], 0, 0);
    apb(1'b1, 32'h00000008, 32'h00000000);
    check("slave error", {11'h000, serr}, 1, 0);
    // Second reset in mid-run: mode and enable back to defaults
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    dev(1'b1, vte_pkg::ADDR_SYSTEM_CONTROL_WORD, 12'h000);
    check("control reset", st[27:16], 0, 0);
    dev(1'b0, vte_pkg::ADDR_CURRENT_IN_U, 12'h309);
    dev(1'b0, vte_pkg::ADDR_CURRENT_IN_V, 12'h064);
    dev(1'b0, vte_pkg::ADDR_CURRENT_IN_W, 12'h0C8);
    dev(1'b0, vte_pkg::ADDR_REVERSE_ANGLE, 12'h800);
    dev(1'b1, vte_pkg::ADDR_ALPHA_CURRENT, 12'h000);
    check("default mode", st[27:16], -300, 3);
    finish_test();
  end
endmodule : test_vector_transform_engine
`default_nettype wire
